// ==== shared/cacc_cfg.svh ====
// register offsets, field positions and reset values for the capture/compare module
// assumes inclusion by the design file, the pin source model and the bench
`ifndef CACC_CFG_SVH
`define CACC_CFG_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CACC_OFS_MODE 4'h0
`define CACC_OFS_CCL 4'h1
`define CACC_OFS_CCH 4'h2
`define CACC_OFS_CTRL 4'h3
`define CACC_OFS_MASK 4'h4
`define CACC_OFS_CNTL 4'h5
`define CACC_OFS_CNTH 4'h6
`define CACC_OFS_PIN 4'h7

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CACC_MODE_ECCF 0
`define CACC_MODE_MAT 3
`define CACC_MODE_CAPN 4
`define CACC_MODE_CAPP 5
`define CACC_MODE_ECOM 6

// ----------------------------------------
// control/status fields
// ----------------------------------------
`define CACC_CTRL_FLAG 0
`define CACC_CTRL_RUN 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define CACC_RST_MODE 8'h00
`define CACC_RST_MASK 8'h01
`define CACC_RST_CC 16'h0000
`define CACC_RST_CNT 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CACC_PIN_HOLD_CYC 2

`endif

// ==== shared/cacc_pkg.sv ====
// types shared by the capture/compare module
// assumes cacc_cfg.svh is compiled alongside
package cacc_pkg;
	typedef logic [7:0] cacc_byte_t;
	typedef logic [15:0] cacc_word_t;
	typedef logic [3:0] cacc_addr_t;
endpackage

// ==== rtl/cacc_core.sv ====
// one capture/compare module with its free running 16-bit counter
// assumes a plain register port, asynchronous pin input and one 50 MHz clock
`timescale 1ns/1ns
`include "cacc_cfg.svh"

module cacc_core #(
	parameter int CNT_W = 16
) (
	clk,
	sys_rst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	module_capture_pin,
	irq
);
	input wire logic clk;
	input wire logic sys_rst;
	input wire cacc_pkg::cacc_addr_t reg_addr;
	input wire cacc_pkg::cacc_byte_t reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output cacc_pkg::cacc_byte_t reg_rdata;
	input wire logic module_capture_pin;
	output logic irq;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] module_mode_register_ff, nxt_module_mode_register;
	logic [CNT_W-1:0] capcomp_ff, nxt_capcomp;
	logic [CNT_W-1:0] count_ff, nxt_count;
	logic run_ff, nxt_run;
	logic capcomp_flag_ff, nxt_capcomp_flag;
	logic [7:0] mask_ff, nxt_mask;
	logic [7:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic sync1_ff, sync2_ff, prev_ff;

	logic rise, fall, cap_hit, cmp_hit, event_hit;
	logic compare_enable, match_flag_enable;
	logic rising_capture_enable, falling_capture_enable;

	function automatic logic addr_is(input cacc_pkg::cacc_addr_t a, input cacc_pkg::cacc_addr_t o);
		return a == o;
	endfunction

	assign compare_enable = module_mode_register_ff[`CACC_MODE_ECOM];
	assign match_flag_enable = module_mode_register_ff[`CACC_MODE_MAT];
	assign rising_capture_enable = module_mode_register_ff[`CACC_MODE_CAPP];
	assign falling_capture_enable = module_mode_register_ff[`CACC_MODE_CAPN];

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// sync and sample
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			sync1_ff <= module_capture_pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;
	assign cap_hit = (rise & rising_capture_enable) | (fall & falling_capture_enable);
	assign cmp_hit = compare_enable & match_flag_enable & (count_ff == capcomp_ff);
	assign event_hit = cap_hit | cmp_hit;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_module_mode_register = module_mode_register_ff;
		nxt_capcomp = capcomp_ff;
		nxt_count = run_ff ? count_ff + CNT_W'(1) : count_ff;
		nxt_run = run_ff;
		nxt_capcomp_flag = capcomp_flag_ff;
		nxt_mask = mask_ff;
		nxt_rdata = 8'h00;
		if (reg_wr) begin
			if (addr_is(reg_addr, `CACC_OFS_MODE)) begin
				nxt_module_mode_register = reg_wdata;
			end else if (addr_is(reg_addr, `CACC_OFS_CCL)) begin
				nxt_capcomp[7:0] = reg_wdata;
				nxt_module_mode_register[`CACC_MODE_ECOM] = 1'b0;
			end else if (addr_is(reg_addr, `CACC_OFS_CCH)) begin
				nxt_capcomp[CNT_W-1:8] = reg_wdata[CNT_W-9:0];
				nxt_module_mode_register[`CACC_MODE_ECOM] = 1'b1;
			end else if (addr_is(reg_addr, `CACC_OFS_CTRL)) begin
				nxt_run = reg_wdata[`CACC_CTRL_RUN];
				if (reg_wdata[`CACC_CTRL_FLAG]) begin
					nxt_capcomp_flag = 1'b0;
				end
			end else if (addr_is(reg_addr, `CACC_OFS_MASK)) begin
				nxt_mask = reg_wdata;
			end else if (addr_is(reg_addr, `CACC_OFS_CNTL)) begin
				nxt_count[7:0] = reg_wdata;
			end else if (addr_is(reg_addr, `CACC_OFS_CNTH)) begin
				nxt_count[CNT_W-1:8] = reg_wdata[CNT_W-9:0];
			end
		end
		if (cap_hit) begin
			nxt_capcomp = count_ff;
		end
		if (event_hit) begin
			nxt_capcomp_flag = 1'b1;
		end
		if (reg_rd) begin
			if (addr_is(reg_addr, `CACC_OFS_MODE)) begin
				nxt_rdata = module_mode_register_ff;
			end else if (addr_is(reg_addr, `CACC_OFS_CCL)) begin
				nxt_rdata = capcomp_ff[7:0];
			end else if (addr_is(reg_addr, `CACC_OFS_CCH)) begin
				nxt_rdata = capcomp_ff[CNT_W-1:8];
			end else if (addr_is(reg_addr, `CACC_OFS_CTRL)) begin
				nxt_rdata = 8'h00;
				nxt_rdata[`CACC_CTRL_RUN] = run_ff;
				nxt_rdata[`CACC_CTRL_FLAG] = capcomp_flag_ff;
			end else if (addr_is(reg_addr, `CACC_OFS_MASK)) begin
				nxt_rdata = mask_ff;
			end else if (addr_is(reg_addr, `CACC_OFS_CNTL)) begin
				nxt_rdata = count_ff[7:0];
			end else if (addr_is(reg_addr, `CACC_OFS_CNTH)) begin
				nxt_rdata = count_ff[CNT_W-1:8];
			end else if (addr_is(reg_addr, `CACC_OFS_PIN)) begin
				nxt_rdata = {7'h00, sync2_ff};
			end
		end
		nxt_irq = nxt_capcomp_flag & nxt_mask[`CACC_CTRL_FLAG]
			& nxt_module_mode_register[`CACC_MODE_ECCF];
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			module_mode_register_ff <= `CACC_RST_MODE;
			capcomp_ff <= `CACC_RST_CC;
			count_ff <= CNT_W'(`CACC_RST_CNT);
			run_ff <= 1'b0;
			capcomp_flag_ff <= 1'b0;
			mask_ff <= `CACC_RST_MASK;
			rdata_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else begin
			module_mode_register_ff <= nxt_module_mode_register;
			capcomp_ff <= nxt_capcomp;
			count_ff <= nxt_count;
			run_ff <= nxt_run;
			capcomp_flag_ff <= nxt_capcomp_flag;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq = irq_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_rise_seen;
		sync2_ff && !prev_ff && rising_capture_enable;
	endsequence

	sequence s_fall_seen;
		!sync2_ff && prev_ff && falling_capture_enable;
	endsequence

	a_capture_loads_count: assert property (@(posedge clk) disable iff (sys_rst)
		(s_rise_seen or s_fall_seen) |=> capcomp_ff == $past(count_ff))
		else $error("capture did not load counter");

	a_edge_select_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(!rising_capture_enable && !falling_capture_enable && !reg_wr
		&& !(compare_enable && match_flag_enable)) |=> $stable(capcomp_ff))
		else $error("capture without enabled edge");

	a_capture_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(s_rise_seen or s_fall_seen) |=> capcomp_flag_ff)
		else $error("flag not set on capture");

	a_irq_follows_flag: assert property (@(posedge clk) disable iff (sys_rst)
		irq_ff == (capcomp_flag_ff && mask_ff[`CACC_CTRL_FLAG]
		&& module_mode_register_ff[`CACC_MODE_ECCF]))
		else $error("interrupt level wrong");

	a_flag_held_set: assert property (@(posedge clk) disable iff (sys_rst)
		capcomp_flag_ff && !(reg_wr && reg_addr == `CACC_OFS_CTRL) |=> capcomp_flag_ff)
		else $error("flag cleared without software");

	a_pin_readback: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `CACC_OFS_PIN |=> reg_rdata[0] == $past(sync2_ff))
		else $error("pin readback wrong");

	a_match_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
		compare_enable && match_flag_enable && count_ff == capcomp_ff |=> capcomp_flag_ff)
		else $error("match did not set flag");

	a_no_timer_no_match: assert property (@(posedge clk) disable iff (sys_rst)
		!capcomp_flag_ff && !match_flag_enable && !rise && !fall |=> !capcomp_flag_ff)
		else $error("flag set outside timer mode");

	a_low_write_clears: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_CCL |=> !compare_enable)
		else $error("low write kept compare enable");

	a_high_write_sets: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_CCH |=> compare_enable)
		else $error("high write left compare enable clear");

	a_sync_edge_delay: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(sync2_ff) |-> ##0 !prev_ff ##1 prev_ff)
		else $error("edge sample chain broken");

	// ----------------------------------------
	// pin to flag walk
	// ----------------------------------------
	sequence s_pin_rose;
		$rose(module_capture_pin) ##2 rising_capture_enable;
	endsequence

	sequence s_pin_fell;
		$fell(module_capture_pin) ##2 falling_capture_enable;
	endsequence

	a_rise_walk_capture: assert property (@(posedge clk) disable iff (sys_rst)
		s_pin_rose |=> capcomp_flag_ff && capcomp_ff == $past(count_ff))
		else $error("rising pin edge not captured in time");

	a_fall_walk_capture: assert property (@(posedge clk) disable iff (sys_rst)
		s_pin_fell |=> capcomp_flag_ff && capcomp_ff == $past(count_ff))
		else $error("falling pin edge not captured in time");

	a_sync_two_stage: assert property (@(posedge clk) disable iff (sys_rst)
		sync2_ff == $past(module_capture_pin, 2))
		else $error("synchroniser depth wrong");

	a_flag_needs_event: assert property (@(posedge clk) disable iff (sys_rst)
		!capcomp_flag_ff && !event_hit |=> !capcomp_flag_ff)
		else $error("flag set without event");

	a_flag_sw_clear: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_CTRL && reg_wdata[`CACC_CTRL_FLAG] && !event_hit
		|=> !capcomp_flag_ff)
		else $error("software clear ignored");

	a_irq_needs_flag: assert property (@(posedge clk) disable iff (sys_rst)
		irq_ff |-> capcomp_flag_ff)
		else $error("interrupt without flag");

	a_irq_gate_mode: assert property (@(posedge clk) disable iff (sys_rst)
		!module_mode_register_ff[`CACC_MODE_ECCF] |-> !irq_ff)
		else $error("interrupt while disabled");

	a_low_byte_load: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_CCL && !cap_hit |=> capcomp_ff[7:0] == $past(reg_wdata))
		else $error("low byte not loaded");

	a_high_byte_load: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_CCH && !cap_hit
		|=> capcomp_ff[CNT_W-1:8] == $past(reg_wdata))
		else $error("high byte not loaded");

	a_mode_write_load: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `CACC_OFS_MODE |=> module_mode_register_ff == $past(reg_wdata))
		else $error("mode write not loaded");

	a_count_runs: assert property (@(posedge clk) disable iff (sys_rst)
		run_ff && !reg_wr |=> count_ff == $past(count_ff) + CNT_W'(1))
		else $error("counter did not advance");

	a_count_holds: assert property (@(posedge clk) disable iff (sys_rst)
		!run_ff && !reg_wr |=> $stable(count_ff))
		else $error("stopped counter moved");
endmodule

// ==== test/cacc_pin_src.sv ====
// outside signal source driving the capture pin
// assumes the bench calls set_level from its own procedural flow
`timescale 1ns/1ns
`include "cacc_cfg.svh"
module cacc_pin_src (
	clk,
	module_capture_pin
);
	input wire logic clk;
	output logic module_capture_pin;
	initial module_capture_pin = 1'b0;
	task automatic set_level(input logic lvl, input int dly);
		repeat (dly + 1) @(posedge clk);
		module_capture_pin <= lvl;
		repeat (`CACC_PIN_HOLD_CYC) @(posedge clk);
	endtask
endmodule

// ==== test/counter_array_capture_compare_tb_top.sv ====
// self-checking bench for the capture/compare module
// assumes the pin source model and the register port contract of cacc_core
`timescale 1ns/1ns
`include "cacc_cfg.svh"
module counter_array_capture_compare_tb_top;
	logic clk, sys_rst, reg_wr, reg_rd, module_capture_pin, irq;
	cacc_pkg::cacc_addr_t reg_addr;
	cacc_pkg::cacc_byte_t reg_wdata, reg_rdata, last_cap;
	int fails = 0;
	int cmp_count = 0;
	cacc_core dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.module_capture_pin(module_capture_pin), .irq(irq));
	cacc_pin_src src (.clk(clk), .module_capture_pin(module_capture_pin));
	// ----------------------------------------
	// bus and compare helpers
	// ----------------------------------------
	task automatic chk(input string nm, input cacc_pkg::cacc_byte_t exp, got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input cacc_pkg::cacc_addr_t a, input cacc_pkg::cacc_byte_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input cacc_pkg::cacc_addr_t a, input cacc_pkg::cacc_byte_t e, input string nm);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(`CACC_OFS_MODE, `CACC_RST_MODE, "mode");
		rd(`CACC_OFS_MASK, `CACC_RST_MASK, "mask");
		rd(`CACC_OFS_CTRL, 8'h00, "ctrl");
		rd(`CACC_OFS_CCH, 8'(`CACC_RST_CC >> 8), "cch");
		wr(4'h9, 8'hff);
		rd(4'h9, 8'h00, "unmapped");
		$display("done reset");
	endtask
	task automatic t_cap(input cacc_pkg::cacc_byte_t md, input logic lvl, hit,
		input cacc_pkg::cacc_byte_t k, input int dly);
		wr(`CACC_OFS_CTRL, 8'h01);
		wr(`CACC_OFS_CNTL, k);
		wr(`CACC_OFS_MODE, md);
		src.set_level(lvl, dly);
		repeat (6) @(posedge clk);
		if (hit)
			last_cap = k;
		rd(`CACC_OFS_CTRL, {7'h00, hit}, "flag");
		rd(`CACC_OFS_CCL, last_cap, "ccl");
		chk("irq", {7'h00, hit}, {7'h00, irq});
		if (md[`CACC_MODE_CAPP] && md[`CACC_MODE_CAPN])
			rd(`CACC_OFS_PIN, {7'h00, lvl}, "pin level");
		$display("done capture mode %h level %b", md, lvl);
	endtask
	task automatic t_irq;
		repeat (10) @(posedge clk);
		rd(`CACC_OFS_CTRL, 8'h01, "flag held");
		rd(`CACC_OFS_CCH, 8'h5a, "cch");
		wr(`CACC_OFS_MASK, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("irq masked", 8'h00, {7'h00, irq});
		wr(`CACC_OFS_MASK, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq unmasked", 8'h01, {7'h00, irq});
		wr(`CACC_OFS_MODE, 8'h30);
		repeat (2) @(posedge clk);
		#1 chk("irq disabled", 8'h00, {7'h00, irq});
		wr(`CACC_OFS_MODE, 8'h31);
		wr(`CACC_OFS_CTRL, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk("irq cleared", 8'h00, {7'h00, irq});
		$display("done interrupt");
	endtask
	task automatic t_timer;
		wr(`CACC_OFS_MODE, 8'h49);
		wr(`CACC_OFS_CCL, 8'h10);
		rd(`CACC_OFS_MODE, 8'h09, "ecom after low");
		wr(`CACC_OFS_CCH, 8'h00);
		rd(`CACC_OFS_MODE, 8'h49, "ecom after high");
		wr(`CACC_OFS_CNTL, 8'h00);
		wr(`CACC_OFS_CNTH, 8'h00);
		wr(`CACC_OFS_CTRL, 8'h41);
		rd(`CACC_OFS_CNTL, 8'h01, "count low");
		rd(`CACC_OFS_CTRL, 8'h40, "early match");
		repeat (20) @(posedge clk);
		rd(`CACC_OFS_CTRL, 8'h41, "match flag");
		chk("irq", 8'h01, {7'h00, irq});
		rd(`CACC_OFS_CNTH, 8'h00, "count high");
		$display("done timer");
	endtask
	// ----------------------------------------
	// clock, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		last_cap = 8'h00;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		wr(`CACC_OFS_CNTH, 8'h5a);
		t_cap(8'h21, 1'b1, 1'b1, 8'h31, 0);
		t_cap(8'h21, 1'b0, 1'b0, 8'h32, 3);
		t_cap(8'h11, 1'b1, 1'b0, 8'h33, 0);
		t_cap(8'h11, 1'b0, 1'b1, 8'h34, 3);
		t_cap(8'h31, 1'b1, 1'b1, 8'h35, 0);
		t_cap(8'h31, 1'b0, 1'b1, 8'h36, 0);
		t_irq;
		t_timer;
		final_report;
	end
	initial begin
		#200000;
		fails++;
		final_report;
	end
endmodule
